//--- quad_dac_command_register_decoder.sv
// Command decoder and register set of a quad voltage-output converter
// Functional notes
// - Frames are 24 bits MSB first: rw, zero, register select, channel, data
// - Channel field 0..3 picks A..D, 4 picks all four channels
// - Register select 000 writes the pending code of the addressed channels
// - With 16 code bits the code is frame bits 15 down to 0
// - With 14 code bits the code is bits 15..2; bits 1..0 ignored
// - With 12 code bits the code is bits 15..4; bits 3..0 ignored
// - Register select 001 sets addressed channel ranges from bits 2..0
// - Range codes 0..2 are unipolar, 3..5 bipolar
// - Register select 011 is control; channel field picks the function
// - Control function 000 does nothing; used to clock out readback
// - Control function 001 loads thermal, clamp, clear select, output disable bits
// - Control function 100 forces all codes to clear code and updates outputs
// - Control function 101 moves pending codes to the active outputs
// - Serial output disable bit stops driving the readback pin; resets to 0
// - Clamp enable, reset 1, keeps overcurrent channels powered with current limit
// - Clamp disabled: a channel with overcurrent is powered down
// - Thermal shutdown enable, reset 0, enables over-temperature power down
// - Clear select 0 gives 0 V; 1 gives midscale or negative full scale
// - Register select 010 is the power control register
`timescale 1ns/100ps
module quad_dac_command_register_decoder
	import dac_cmd_pkg::*;
#(
	parameter int CODE_BITS = CODE_BITS_DEFAULT
) (
	// Clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              rst_b,
	// Serial port
	input  wire logic                              serial_clock,
	input  wire logic                              frame_sync_b,
	input  wire logic                              serial_command_input,
	output logic                                   serial_readback_output,
	output logic                                   serial_readback_oe,
	// Status and strap pins
	input  wire logic                              twos_complement_mode,
	input  wire logic [NUM_CHANNELS-1:0]           overcurrent_detect,
	input  wire logic                              over_temp_detect,
	// Converter control outputs
	output logic [NUM_CHANNELS*DATA_BITS-1:0]      dac_code,
	output logic [NUM_CHANNELS*RANGE_BITS-1:0]     output_range,
	output logic [NUM_CHANNELS-1:0]                channel_power_up,
	output logic                                   current_clamp_en,
	output logic                                   thermal_shutdown_en,
	output logic                                   clear_select,
	output logic                                   thermal_shutdown
);
	localparam int LOW_BITS = DATA_BITS - CODE_BITS;
	localparam logic [DATA_BITS-1:0] CODE_MASK = 16'hffff << LOW_BITS;

	if (CODE_BITS != 16 && CODE_BITS != 14 && CODE_BITS != 12) begin : g_bad_width
		$error("CODE_BITS must be 12, 14 or 16");
	end

	// Channel field to channel mask, zero for undefined codes
	function automatic logic [NUM_CHANNELS-1:0] chan_decode(input logic [2:0] chan);
		logic [NUM_CHANNELS-1:0] mask;
		mask = '0;
		if (chan == CHAN_ALL) begin
			mask = '1;
		end else if (chan < CHAN_ALL) begin
			mask[chan[1:0]] = 1'b1;
		end
		return mask;
	endfunction

	function automatic logic is_bipolar(input logic [RANGE_BITS-1:0] range);
		return range >= RANGE_BIPOLAR_MIN;
	endfunction

	// Code giving the selected clear level for one channel
	function automatic logic [DATA_BITS-1:0] clear_code(input logic [RANGE_BITS-1:0] range,
		input logic sel, input logic twos);
		logic [DATA_BITS-1:0] code;
		code = CODE_ZERO;
		if (!is_bipolar(range)) begin
			code = sel ? CODE_MID : CODE_ZERO;
		end else if (twos) begin
			code = sel ? CODE_MID : CODE_ZERO;
		end else begin
			code = sel ? CODE_ZERO : CODE_MID;
		end
		return code;
	endfunction

	serial_frame_if frm ();

	serial_frame_shifter u_shifter (
		.core_clk               (core_clk),
		.rst_b                  (rst_b),
		.serial_clock           (serial_clock),
		.frame_sync_b           (frame_sync_b),
		.serial_command_input   (serial_command_input),
		.serial_readback_output (serial_readback_output),
		.serial_readback_oe     (serial_readback_oe),
		.frm                    (frm.link)
	);

	logic [DATA_BITS-1:0]    pending_code [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] oc_m, oc_s;
	logic                    ot_m, ot_s;
	logic                    twos_m, twos_s;
	logic                    sdo_disable;
	logic [NUM_CHANNELS-1:0] oc_alert;
	logic [FRAME_BITS-1:0]   readback_word;
	logic [NUM_CHANNELS-1:0] next_power;

	// Frame field decode
	wire [FRAME_BITS-1:0]   w        = frm.frame_word;
	wire                    is_write = frm.frame_valid & ~w[RW_BIT];
	wire                    is_read  = frm.frame_valid & w[RW_BIT];
	wire [2:0]              reg_sel  = w[REG_SEL_HI:REG_SEL_LO];
	wire [2:0]              chan     = w[CHAN_HI:CHAN_LO];
	wire [DATA_BITS-1:0]    data     = w[DATA_BITS-1:0];
	wire [RANGE_BITS-1:0]   range_in = data[RANGE_BITS-1:0];
	wire [NUM_CHANNELS-1:0] chan_mask = chan_decode(chan);
	wire                    ctl_wr   = is_write && reg_sel == REG_CONTROL;
	wire                    code_wr  = is_write && reg_sel == REG_CODE && chan_mask != '0;
	wire                    range_wr = is_write && reg_sel == REG_RANGE && chan_mask != '0
		&& range_in <= RANGE_MAX;
	wire                    power_wr = is_write && reg_sel == REG_POWER;
	wire                    cfg_wr   = ctl_wr && chan == CTL_CONFIG;
	wire                    clear_cmd = ctl_wr && chan == CTL_CLEAR;
	wire                    load_cmd = ctl_wr && chan == CTL_LOAD;
	wire                    power_rd = is_read && reg_sel == REG_POWER;
	wire [DATA_BITS-1:0]    code_in  = data & CODE_MASK;

	// Protection trips
	wire [NUM_CHANNELS-1:0] oc_trip  = oc_s & {NUM_CHANNELS{~current_clamp_en}};
	wire                    heat_trip = ot_s & thermal_shutdown_en;

	wire [DATA_BITS-1:0] clear_value [NUM_CHANNELS];
	for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_clear
		assign clear_value[ch] = clear_code(output_range[ch*RANGE_BITS +: RANGE_BITS],
			clear_select, twos_s);
	end

	// Readback data of the addressed register
	wire [DATA_BITS-1:0] power_word = {5'h00, oc_alert, 1'b0, thermal_shutdown, 1'b0,
		channel_power_up};
	wire [DATA_BITS-1:0] cfg_word = {12'h000, thermal_shutdown_en, current_clamp_en,
		clear_select, sdo_disable};
	wire [DATA_BITS-1:0] range_word = (chan < CHAN_ALL) ?
		{13'h0000, output_range[chan[1:0]*RANGE_BITS +: RANGE_BITS]} : 16'h0000;
	wire [DATA_BITS-1:0] code_word = (chan < CHAN_ALL) ? pending_code[chan[1:0]] : 16'h0000;
	wire [DATA_BITS-1:0] rd_data =
		(reg_sel == REG_CODE) ? code_word :
		(reg_sel == REG_RANGE) ? range_word :
		(reg_sel == REG_POWER) ? power_word :
		(reg_sel == REG_CONTROL && chan == CTL_CONFIG) ? cfg_word : 16'h0000;

	assign frm.readback_word = readback_word;
	assign frm.sdo_disable = sdo_disable;
	assign next_power = (power_wr ? data[NUM_CHANNELS-1:0] : channel_power_up)
		& ~oc_trip & {NUM_CHANNELS{~heat_trip}};

	// Pin synchronisers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{oc_m, oc_s} <= '0;
			{ot_m, ot_s} <= 2'h0;
			{twos_m, twos_s} <= 2'h0;
		end else begin
			{oc_m, oc_s} <= {overcurrent_detect, oc_m};
			{ot_m, ot_s} <= {over_temp_detect, ot_m};
			{twos_m, twos_s} <= {twos_complement_mode, twos_m};
		end
	end

	// Pending and active channel codes
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				pending_code[ch] <= CODE_ZERO;
			end
			dac_code <= '0;
		end else begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (clear_cmd) begin
					pending_code[ch] <= clear_value[ch];
					dac_code[ch*DATA_BITS +: DATA_BITS] <= clear_value[ch];
				end else begin
					if (code_wr && chan_mask[ch]) begin
						pending_code[ch] <= code_in;
					end
					if (load_cmd) begin
						dac_code[ch*DATA_BITS +: DATA_BITS] <= pending_code[ch];
					end
				end
			end
		end
	end

	// Output ranges
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			output_range <= {NUM_CHANNELS{RANGE_RESET}};
		end else begin
			for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
				if (range_wr && chan_mask[ch]) begin
					output_range[ch*RANGE_BITS +: RANGE_BITS] <= range_in;
				end
			end
		end
	end

	// Configuration bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sdo_disable <= SDO_DIS_RESET;
			clear_select <= CLR_SEL_RESET;
			current_clamp_en <= CLAMP_RESET;
			thermal_shutdown_en <= THERM_EN_RESET;
		end else if (cfg_wr) begin
			sdo_disable <= data[CFG_SDO_DIS];
			clear_select <= data[CFG_CLR_SEL];
			current_clamp_en <= data[CFG_CLAMP];
			thermal_shutdown_en <= data[CFG_THERM_EN];
		end
	end

	// Power state, alerts and readback word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			channel_power_up <= '0;
			thermal_shutdown <= 1'b0;
			oc_alert <= '0;
			readback_word <= '0;
		end else begin
			channel_power_up <= next_power;
			thermal_shutdown <= heat_trip | (thermal_shutdown & ~power_rd);
			oc_alert <= oc_s | (oc_alert & ~{NUM_CHANNELS{power_rd}});
			if (is_read) begin
				readback_word <= {w[FRAME_BITS-1:DATA_BITS], rd_data};
			end
		end
	end

	// Checks
	a_load_copies: assert property (@(posedge core_clk) disable iff (!rst_b)
		load_cmd |=> dac_code[DATA_BITS-1:0] == $past(pending_code[0]))
		else $error("load did not move pending code to output");

	a_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clear_cmd && !clear_select && !is_bipolar(output_range[2:0]))
		|=> dac_code[DATA_BITS-1:0] == CODE_ZERO && pending_code[0] == CODE_ZERO)
		else $error("clear did not give zero code on unipolar channel");

	a_clear_negfs: assert property (@(posedge core_clk) disable iff (!rst_b)
		(clear_cmd && clear_select && !twos_s && is_bipolar(output_range[5:3]))
		|=> dac_code[2*DATA_BITS-1:DATA_BITS] == CODE_ZERO)
		else $error("clear select 1 did not give negative full scale");

	a_code_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
		code_wr && chan_mask[1] |=> pending_code[1] == ($past(data) & CODE_MASK))
		else $error("code write stored wrong bits");

	a_code_no_update: assert property (@(posedge core_clk) disable iff (!rst_b)
		code_wr && !ctl_wr |=> $stable(dac_code))
		else $error("code write changed output without load");

	a_range_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		range_wr && chan_mask[2] |=> output_range[8:6] == $past(range_in))
		else $error("range write not stored");

	a_range_bad: assert property (@(posedge core_clk) disable iff (!rst_b)
		(is_write && reg_sel == REG_RANGE && range_in > RANGE_MAX) |=> $stable(output_range))
		else $error("undefined range code changed a range");

	a_config_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr |=> current_clamp_en == $past(data[CFG_CLAMP])
			&& sdo_disable == $past(data[CFG_SDO_DIS]))
		else $error("configuration bits not loaded");

	a_oc_powerdown: assert property (@(posedge core_clk) disable iff (!rst_b)
		(oc_s[0] && !current_clamp_en) |=> !channel_power_up[0])
		else $error("overcurrent channel not powered down");

	a_heat_powerdown: assert property (@(posedge core_clk) disable iff (!rst_b)
		heat_trip |=> channel_power_up == '0 && thermal_shutdown)
		else $error("thermal shutdown did not power down");

	a_sdo_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		sdo_disable && $past(sdo_disable) |-> !serial_readback_oe)
		else $error("readback pin driven while disabled");

	a_code_all_chan: assert property (@(posedge core_clk) disable iff (!rst_b)
		code_wr && chan == CHAN_ALL |=> pending_code[3] == $past(code_in))
		else $error("broadcast code write missed channel D");

	a_code_bad_chan: assert property (@(posedge core_clk) disable iff (!rst_b)
		(is_write && reg_sel == REG_CODE && chan > CHAN_ALL) |=> $stable(pending_code[0]))
		else $error("undefined channel changed a code");

	a_code_low_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		code_wr && chan_mask[0] |=> (pending_code[0] & ~CODE_MASK) == 16'h0000)
		else $error("ignored low code bits were stored");

	a_range_all_chan: assert property (@(posedge core_clk) disable iff (!rst_b)
		range_wr && chan == CHAN_ALL |=> output_range == {NUM_CHANNELS{$past(range_in)}})
		else $error("broadcast range write not stored everywhere");

	a_range_single: assert property (@(posedge core_clk) disable iff (!rst_b)
		range_wr && chan == 3'h0 |=> output_range[11:3] == $past(output_range[11:3]))
		else $error("range write touched another channel");

	a_nop_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctl_wr && chan == CTL_NOP |=> $stable(dac_code) && $stable(output_range)
			&& $stable({sdo_disable, clear_select, current_clamp_en, thermal_shutdown_en}))
		else $error("no-operation frame changed a register");

	a_undef_reg: assert property (@(posedge core_clk) disable iff (!rst_b)
		is_write && reg_sel[2] |=> $stable(dac_code) && $stable(output_range))
		else $error("undefined register select changed a register");

	a_load_chan_d: assert property (@(posedge core_clk) disable iff (!rst_b)
		load_cmd |=> dac_code[NUM_CHANNELS*DATA_BITS-1 -: DATA_BITS] == $past(pending_code[3]))
		else $error("load did not move channel D code");

	a_clear_matches: assert property (@(posedge core_clk) disable iff (!rst_b)
		clear_cmd |=> pending_code[3] == dac_code[NUM_CHANNELS*DATA_BITS-1 -: DATA_BITS])
		else $error("clear left pending and active codes apart");

	a_clamp_keeps_power: assert property (@(posedge core_clk) disable iff (!rst_b)
		current_clamp_en && !heat_trip && !power_wr |=> $stable(channel_power_up))
		else $error("channel powered down while clamp enabled");

	a_power_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		power_wr && !heat_trip && oc_trip == '0 |=> channel_power_up == $past(data[3:0]))
		else $error("power register write not stored");

	a_heat_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
		thermal_shutdown && !power_rd |=> thermal_shutdown)
		else $error("thermal alert cleared without a read");

	a_config_rest: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr |=> clear_select == $past(data[CFG_CLR_SEL])
			&& thermal_shutdown_en == $past(data[CFG_THERM_EN]))
		else $error("clear select or thermal enable not loaded");

	a_read_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
		is_read |=> readback_word[FRAME_BITS-1:DATA_BITS] == $past(w[FRAME_BITS-1:DATA_BITS]))
		else $error("read frame header not latched for readback");
endmodule

//--- dac_cmd_pkg.sv
// Shared constants for the quad converter serial command decoder
package dac_cmd_pkg;
	localparam int FRAME_BITS   = 24;
	localparam int DATA_BITS    = 16;
	localparam int NUM_CHANNELS = 4;
	localparam int RANGE_BITS   = 3;
	localparam int CFG_BITS     = 4;
	localparam int CODE_BITS_DEFAULT = 16;
	localparam int COUNT_BITS   = 5;

	// Frame field positions
	localparam int RW_BIT      = 23;
	localparam int ZERO_BIT    = 22;
	localparam int REG_SEL_HI  = 21;
	localparam int REG_SEL_LO  = 19;
	localparam int CHAN_HI     = 18;
	localparam int CHAN_LO     = 16;

	// Register select codes
	localparam logic [2:0] REG_CODE    = 3'h0;
	localparam logic [2:0] REG_RANGE   = 3'h1;
	localparam logic [2:0] REG_POWER   = 3'h2;
	localparam logic [2:0] REG_CONTROL = 3'h3;

	// Channel address codes
	localparam logic [2:0] CHAN_ALL    = 3'h4;

	// Control functions carried in the channel address field
	localparam logic [2:0] CTL_NOP     = 3'h0;
	localparam logic [2:0] CTL_CONFIG  = 3'h1;
	localparam logic [2:0] CTL_CLEAR   = 3'h4;
	localparam logic [2:0] CTL_LOAD    = 3'h5;

	// Range codes
	localparam logic [2:0] RANGE_MAX         = 3'h5;
	localparam logic [2:0] RANGE_BIPOLAR_MIN = 3'h3;
	localparam logic [2:0] RANGE_RESET       = 3'h0;

	// Configuration bit positions and reset values
	localparam int CFG_SDO_DIS = 0;
	localparam int CFG_CLR_SEL = 1;
	localparam int CFG_CLAMP   = 2;
	localparam int CFG_THERM_EN = 3;
	localparam logic CLAMP_RESET   = 1'b1;
	localparam logic SDO_DIS_RESET = 1'b0;
	localparam logic CLR_SEL_RESET = 1'b0;
	localparam logic THERM_EN_RESET = 1'b0;

	// Power register field positions
	localparam int PWR_THERM_BIT = 5;
	localparam int PWR_OC_LO   = 7;

	// Code values used for clearing
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID  = 16'h8000;

	typedef enum {LINK_IDLE, LINK_SHIFT, LINK_WAIT_END} link_state_t;
endpackage

//--- serial_frame_if.sv
// Frame and readback signals between the serial shifter and the decoder
`timescale 1ns/100ps
interface serial_frame_if;
	import dac_cmd_pkg::*;
	logic [FRAME_BITS-1:0] frame_word;
	logic                  frame_valid;
	logic [FRAME_BITS-1:0] readback_word;
	logic                  sdo_disable;
	modport link (output frame_word, frame_valid, input readback_word, sdo_disable);
	modport decode (input frame_word, frame_valid, output readback_word, sdo_disable);
endinterface

//--- serial_frame_shifter.sv
// Samples the serial pins and assembles 24-bit command frames
`timescale 1ns/100ps
module serial_frame_shifter
	import dac_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Serial pins
	input  wire logic       serial_clock,
	input  wire logic       frame_sync_b,
	input  wire logic       serial_command_input,
	output logic            serial_readback_output,
	output logic            serial_readback_oe,
	// Decoder side
	serial_frame_if.link    frm
);
	logic                  sclk_m, sclk_s, sclk_d;
	logic                  sync_m, sync_s;
	logic                  din_m, din_s;
	link_state_t           state;
	logic [COUNT_BITS-1:0] bit_cnt;
	logic [FRAME_BITS-1:0] rx_shift;
	logic [FRAME_BITS-1:0] tx_shift;

	wire sclk_fall = sclk_d & ~sclk_s;
	wire sclk_rise = ~sclk_d & sclk_s;
	wire last_bit  = (bit_cnt == COUNT_BITS'(FRAME_BITS - 1));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{sclk_m, sclk_s, sclk_d} <= 3'h7;
			{sync_m, sync_s} <= 2'h3;
			{din_m, din_s} <= 2'h0;
		end else begin
			{sclk_m, sclk_s, sclk_d} <= {serial_clock, sclk_m, sclk_s};
			{sync_m, sync_s} <= {frame_sync_b, sync_m};
			{din_m, din_s} <= {serial_command_input, din_m};
		end
	end

	// Bits taken on falling serial clock, most significant first
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= LINK_IDLE;
			bit_cnt <= '0;
			rx_shift <= '0;
			tx_shift <= '0;
			frm.frame_word <= '0;
			frm.frame_valid <= 1'b0;
			serial_readback_output <= 1'b0;
			serial_readback_oe <= 1'b0;
		end else begin
			frm.frame_valid <= 1'b0;
			serial_readback_oe <= ~sync_s & ~frm.sdo_disable;
			case (state)
				LINK_IDLE: begin
					if (!sync_s) begin
						state <= LINK_SHIFT;
						bit_cnt <= '0;
						tx_shift <= frm.readback_word;
						serial_readback_output <= frm.readback_word[FRAME_BITS-1];
					end
				end
				LINK_SHIFT: begin
					if (sync_s) begin
						state <= LINK_IDLE;
					end else if (sclk_fall) begin
						rx_shift <= {rx_shift[FRAME_BITS-2:0], din_s};
						bit_cnt <= bit_cnt + COUNT_BITS'(1);
						if (last_bit) begin
							frm.frame_word <= {rx_shift[FRAME_BITS-2:0], din_s};
							frm.frame_valid <= 1'b1;
							state <= LINK_WAIT_END;
						end
					end else if (sclk_rise) begin
						tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
						serial_readback_output <= tx_shift[FRAME_BITS-2];
					end
				end
				LINK_WAIT_END: begin
					if (sync_s) begin
						state <= LINK_IDLE;
					end
				end
				default: state <= LINK_IDLE;
			endcase
		end
	end

	a_frame_single: assert property (@(posedge core_clk) disable iff (!rst_b)
		frm.frame_valid |=> !frm.frame_valid)
		else $error("frame strobe lasted more than one cycle");
endmodule

//--- host_serial_model.sv
// Host serial port model that shifts command frames and captures readback
`timescale 1ns/100ps
module host_serial_model (
	// Serial pins
	output logic      serial_clock,
	output logic      frame_sync_b,
	output logic      serial_command_input,
	input  wire logic serial_readback_output,
	input  wire logic serial_readback_oe
);
	logic [23:0] rx_word;
	logic        oe_seen;
	realtime     half_ns;
	initial begin
		serial_clock = 1'b1;
		frame_sync_b = 1'b1;
		serial_command_input = 1'b0;
		rx_word = 24'h000000;
		oe_seen = 1'b0;
		half_ns = 62.5;
	end
	// Clock idles high; the device takes each bit on the falling edge
	task automatic send_frame(input logic [23:0] word);
		oe_seen = 1'b0;
		#13.7;
		frame_sync_b = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			serial_command_input = word[i];
			#(half_ns);
			rx_word[i] = serial_readback_oe ? serial_readback_output : ~serial_readback_output;
			oe_seen = oe_seen | serial_readback_oe;
			serial_clock = 1'b0;
			#(half_ns);
			serial_clock = 1'b1;
		end
		#(half_ns);
		frame_sync_b = 1'b1;
		serial_command_input = ~word[0];
		#(half_ns);
	endtask
endmodule

//--- quad_dac_command_register_decoder_tb.sv
// Self-checking bench for the quad converter command decoder
`timescale 1ns/100ps
module quad_dac_command_register_decoder_tb;
	import dac_cmd_pkg::*;
	logic        core_clk;
	logic        rst_b;
	logic        serial_clock;
	logic        frame_sync_b;
	logic        serial_command_input;
	logic        serial_readback_output;
	logic        serial_readback_oe;
	logic        twos_complement_mode;
	logic [3:0]  overcurrent_detect;
	logic        over_temp_detect;
	logic [63:0] dac_code;
	logic [11:0] output_range;
	logic [3:0]  channel_power_up;
	logic        current_clamp_en;
	logic        thermal_shutdown_en;
	logic        clear_select;
	logic        thermal_shutdown;
	int          failures;
	int          checked;

	quad_dac_command_register_decoder #(.CODE_BITS(16)) u_quad_dac_command_register_decoder (
		.core_clk(core_clk), .rst_b(rst_b), .serial_clock(serial_clock),
		.frame_sync_b(frame_sync_b), .serial_command_input(serial_command_input),
		.serial_readback_output(serial_readback_output), .serial_readback_oe(serial_readback_oe),
		.twos_complement_mode(twos_complement_mode), .overcurrent_detect(overcurrent_detect),
		.over_temp_detect(over_temp_detect), .dac_code(dac_code), .output_range(output_range),
		.channel_power_up(channel_power_up), .current_clamp_en(current_clamp_en),
		.thermal_shutdown_en(thermal_shutdown_en), .clear_select(clear_select),
		.thermal_shutdown(thermal_shutdown));
	host_serial_model u_host_serial_model (
		.serial_clock(serial_clock), .frame_sync_b(frame_sync_b),
		.serial_command_input(serial_command_input),
		.serial_readback_output(serial_readback_output), .serial_readback_oe(serial_readback_oe));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	task automatic check_code(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [23:0] cmd(logic [2:0] r, logic [2:0] a, logic [15:0] d);
		return {2'b00, r, a, d};
	endfunction
	task automatic frame(input logic [23:0] w);
		u_host_serial_model.send_frame(w);
		repeat (4) @(negedge core_clk);
	endtask
	task automatic settle();
		repeat (12) @(negedge core_clk);
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		check_code(dac_code, 64'h0);
		check_val(output_range, 24'h0);
		check_val(channel_power_up, 24'h0);
		check_val(current_clamp_en, 24'h1);
		check_val(thermal_shutdown_en, 24'h0);
		check_val(clear_select, 24'h0);
		check_val(serial_readback_oe, 24'h0);
		check_val(thermal_shutdown, 24'h0);
	endtask
	task automatic t_code();
		logic [63:0] exp;
		exp = 64'h0;
		for (int c = 0; c < 4; c++) begin
			exp[c*16 +: 16] = 16'h1111 * 16'(c + 1);
			frame(cmd(REG_CODE, c[2:0], 16'h1111 * 16'(c + 1)));
		end
		check_code(dac_code, 64'h0);
		frame(cmd(REG_CONTROL, CTL_LOAD, 16'hffff));
		check_code(dac_code, exp);
		frame(cmd(REG_CODE, 3'h5, 16'h0bad));
		frame(cmd(REG_CONTROL, CTL_LOAD, 16'h0000));
		check_code(dac_code, exp);
		frame(cmd(REG_CODE, CHAN_ALL, 16'hfedc));
		frame(cmd(REG_CONTROL, CTL_LOAD, 16'h0000));
		check_code(dac_code, {4{16'hfedc}});
	endtask
	task automatic t_range();
		for (int r = 0; r < 6; r++) begin
			frame(cmd(REG_RANGE, 3'h2, 16'hfff8 | 16'(r)));
			check_val(output_range, 24'(r) << 6);
		end
		frame(cmd(REG_RANGE, 3'h2, 16'h0006));
		check_val(output_range, 24'h140);
		frame(cmd(REG_RANGE, CHAN_ALL, 16'h0003));
		check_val(output_range, 24'h6db);
		frame(cmd(REG_RANGE, 3'h0, 16'h0001));
	endtask
	task automatic t_clear();
		frame(cmd(REG_CONTROL, CTL_CLEAR, 16'hffff));
		check_code(dac_code, {{3{16'h8000}}, 16'h0000});
		frame(cmd(REG_CONTROL, CTL_CONFIG, 16'hfff6));
		check_val({current_clamp_en, clear_select, thermal_shutdown_en}, 24'h6);
		frame(cmd(REG_CONTROL, CTL_CLEAR, 16'h0000));
		check_code(dac_code, {{3{16'h0000}}, 16'h8000});
		@(negedge core_clk) twos_complement_mode = 1'b1;
		settle();
		frame(cmd(REG_CONTROL, CTL_CLEAR, 16'h0000));
		check_code(dac_code, {4{16'h8000}});
	endtask
	task automatic t_nop();
		frame(cmd(REG_CONTROL, CTL_NOP, 16'hffff));
		frame(cmd(3'h4, 3'h0, 16'h1234));
		frame(cmd(REG_CONTROL, 3'h2, 16'h0000));
		frame(cmd(REG_RANGE, 3'h1, 16'h0007));
		frame(cmd(REG_CONTROL, CTL_LOAD, 16'h0000));
		check_code(dac_code, {4{16'h8000}});
		check_val(output_range, 24'h6d9);
	endtask
	task automatic t_readback();
		frame(cmd(REG_CODE, 3'h1, 16'habcd));
		frame(24'h810000);
		frame(cmd(REG_CONTROL, CTL_NOP, 16'h0000));
		check_val(u_host_serial_model.rx_word, 24'h81abcd);
		check_val(u_host_serial_model.oe_seen, 24'h1);
		check_code(dac_code, {4{16'h8000}});
		frame(cmd(REG_CONTROL, CTL_CONFIG, 16'h0007));
		frame(24'h810000);
		frame(cmd(REG_CONTROL, CTL_NOP, 16'h0000));
		check_val(u_host_serial_model.oe_seen, 24'h0);
	endtask
	task automatic t_power();
		frame(cmd(REG_POWER, 3'h0, 16'h000f));
		check_val(channel_power_up, 24'hf);
		@(negedge core_clk) overcurrent_detect = 4'h1;
		settle();
		check_val(channel_power_up, 24'hf);
		@(negedge core_clk) overcurrent_detect = 4'h0;
		frame(cmd(REG_CONTROL, CTL_CONFIG, 16'h0000));
		check_val(current_clamp_en, 24'h0);
		@(negedge core_clk) overcurrent_detect = 4'h2;
		settle();
		check_val(channel_power_up, 24'hd);
		@(negedge core_clk) overcurrent_detect = 4'h0;
		frame(cmd(REG_CONTROL, CTL_CONFIG, 16'h0008));
		check_val(thermal_shutdown_en, 24'h1);
		@(negedge core_clk) over_temp_detect = 1'b1;
		settle();
		check_val({thermal_shutdown, channel_power_up}, 24'h10);
		@(negedge core_clk) over_temp_detect = 1'b0;
	endtask

	initial begin
		failures = 0;
		checked = 0;
		rst_b = 1'b0;
		twos_complement_mode = 1'b0;
		overcurrent_detect = 4'h0;
		over_temp_detect = 1'b0;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk) rst_b = 1'b1;
		repeat (5) @(negedge core_clk);
		t_reset();
		t_code();
		t_range();
		t_clear();
		t_nop();
		t_readback();
		t_power();
		summarize();
	end

	// About forty frames of 3.2 us, wide margin
	initial begin
		#400000;
		failures++;
		summarize();
	end
endmodule
